// ===== inc/svi_pkg.sv
// Shared types of the ingress classifier
package svi_pkg;
  typedef enum logic [1:0] {
    SVI_IDLE = 2'b01,
    SVI_BUSY = 2'b10
  } svi_cmd_type;
endpackage

// ===== inc/svi_regs.svh
// Register map, field positions, reset values and rule summary of the ingress classifier
// Operation
// - Port default priority from PVID entry, bcast separate
// - IP precedence: top three TOS bits
// - DSCP: upper six bits index table
// - DSCP table result goes through traffic class
// - PVID table via indirect command registers
// - DSCP table via indirect command registers
// - Tag priority remapped per port
// - Sixteen VLAN entries: VID, members, untag
// - Valid tagged VID searched; hit gives membership
// - Miss means empty membership, filter if checking
// - Empty membership filtered; unknown DA floods to all other ports
// - Untagged or VID 0 uses port default
// - Tag VLAN disable forces port default VID
// - Membership checks; untag only on hybrid ports
// - Port state codes 11,01,10,00
// - Disabled: no receive, transmit or learning
// - Blocking/learning discard unless override
// - Learn only in learning and forwarding
// - Forwarding passes traffic normally
// - Host override reaches non-disabled ports only
// - Priority mapped to one of four queues
// - Tagged VID FFF filtered with VLAN enabled
`ifndef SVI_REGS_SVH
`define SVI_REGS_SVH

`define SVI_A_GLOBAL     8'h00
`define SVI_A_STP        8'h04
`define SVI_A_REMAP0     8'h08
`define SVI_A_REMAP1     8'h0C
`define SVI_A_REMAP2     8'h10
`define SVI_A_TCLASS     8'h14
`define SVI_A_VCMD       8'h18
`define SVI_A_VWR        8'h1C
`define SVI_A_VRD        8'h20
`define SVI_A_VSTS       8'h24
`define SVI_A_DCMD       8'h28
`define SVI_A_DWR        8'h2C
`define SVI_A_DRD        8'h30
`define SVI_A_DSTS       8'h34
`define SVI_A_HYBRID     8'h38

`define SVI_G_VLAN_EN    0
`define SVI_G_TAG_DIS    1
`define SVI_G_PSEL_LO    2
`define SVI_G_MEMCHK     4
`define SVI_C_WRITE      30

`define SVI_PSEL_DEF     2'h0
`define SVI_PSEL_IPP     2'h1
`define SVI_PSEL_DSCP    2'h2
`define SVI_PSEL_TAG     2'h3

`define SVI_ST_FWD       2'h0
`define SVI_ST_BLOCK     2'h1
`define SVI_ST_LEARN     2'h2
`define SVI_ST_DIS       2'h3

`define SVI_E_VALID      18
`define SVI_E_MEM_LO     12
`define SVI_E_UNT_LO     15
`define SVI_P_PRIO_LO    12
`define SVI_P_BPRIO_LO   15

`define SVI_VID_NONE     12'h000
`define SVI_VID_RSVD     12'hFFF
`define SVI_REMAP_RST    24'hFA_C688
`define SVI_TCLASS_RST   16'hFA50

`endif

// ===== rtl/svi_ingress.sv
// Ingress priority, VLAN and spanning tree classifier with Wishbone registers
//
// Local design decisions: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "svi_regs.svh"

module svi_ingress #(
  parameter int NUM_VLAN = 16,
  parameter int NUM_PORT = 3
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        pkt_valid,
  input  wire logic [1:0]  pkt_port,
  input  wire logic        pkt_tagged,
  input  wire logic [11:0] pkt_vid,
  input  wire logic [2:0]  pkt_tag_prio,
  input  wire logic        pkt_is_ipv4,
  input  wire logic        pkt_is_ipv6,
  input  wire logic [7:0]  pkt_tos,
  input  wire logic        pkt_bcast,
  input  wire logic        pkt_da_hit,
  input  wire logic [2:0]  pkt_da_ports,
  input  wire logic        pkt_stp_override,
  output logic             res_valid,
  output logic             res_drop,
  output logic      [2:0]  res_prio,
  output logic      [1:0]  res_queue,
  output logic      [11:0] res_vid,
  output logic      [2:0]  res_dest,
  output logic      [2:0]  res_untag,
  output logic             res_learn
);

  localparam int VW = $clog2(NUM_VLAN);
  localparam logic [4:0] PV_BASE = 5'(NUM_VLAN);
  localparam logic [4:0] PV_END = 5'(NUM_VLAN + NUM_PORT);

  typedef struct packed {
    logic [4:0]                glb;
    logic [NUM_PORT-1:0][1:0]  stp;
    logic [NUM_PORT-1:0][23:0] remap;
    logic [7:0][1:0]           tclass;
    logic [NUM_PORT-1:0]       hybrid;
    logic [31:0]               vcmd;
    logic [31:0]               vwr;
    logic [31:0]               vrd;
    svi_pkg::svi_cmd_type      vst;
    logic [NUM_VLAN-1:0][18:0] vtab;
    logic [NUM_PORT-1:0][17:0] pvid;
    logic [31:0]               dcmd;
    logic [31:0]               dwr;
    logic [31:0]               drd;
    svi_pkg::svi_cmd_type      dst;
    logic [63:0][2:0]          dtab;
    logic                      ack;
    logic [31:0]               dat;
    logic                      valid;
    logic                      drop;
    logic [2:0]                prio;
    logic [1:0]                queue;
    logic [11:0]               vid;
    logic [2:0]                dest;
    logic [2:0]                untag;
    logic                      learn;
  } svi_state_type;

  svi_state_type r_reg;
  svi_state_type r_next;

  logic        req;
  logic        wr;
  logic [31:0] wmask;
  logic [31:0] rdata;
  logic [1:0]  sp;
  logic [1:0]  st_src;
  logic [17:0] pv;
  logic        use_pvid;
  logic [11:0] vid;
  logic        hit;
  logic [2:0]  mem;
  logic [2:0]  unt;
  logic [2:0]  dprio;
  logic [2:0]  prio;
  logic [2:0]  cand;
  logic        drop;
  logic [4:0]  vidx;
  logic [4:0]  pidx;
  logic [5:0]  didx;

  assign req = wb_cyc_i & wb_stb_i & ~r_reg.ack;
  assign wr = req & wb_we_i;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] m,
                                        input logic [31:0] d);
    merge = (old & ~m) | (d & m);
  endfunction

  // Unmapped offsets read zero and still acknowledge
  always_comb begin
    case (wb_adr_i)
      `SVI_A_GLOBAL: rdata = {27'h000_0000, r_reg.glb};
      `SVI_A_STP:    rdata = {26'h000_0000, r_reg.stp};
      `SVI_A_REMAP0: rdata = {8'h00, r_reg.remap[0]};
      `SVI_A_REMAP1: rdata = {8'h00, r_reg.remap[1]};
      `SVI_A_REMAP2: rdata = {8'h00, r_reg.remap[2]};
      `SVI_A_TCLASS: rdata = {16'h0000, r_reg.tclass};
      `SVI_A_VCMD:   rdata = r_reg.vcmd;
      `SVI_A_VWR:    rdata = r_reg.vwr;
      `SVI_A_VRD:    rdata = r_reg.vrd;
      `SVI_A_VSTS:   rdata = {31'h0000_0000, r_reg.vst == svi_pkg::SVI_BUSY};
      `SVI_A_DCMD:   rdata = r_reg.dcmd;
      `SVI_A_DWR:    rdata = r_reg.dwr;
      `SVI_A_DRD:    rdata = r_reg.drd;
      `SVI_A_DSTS:   rdata = {31'h0000_0000, r_reg.dst == svi_pkg::SVI_BUSY};
      `SVI_A_HYBRID: rdata = {29'h0000_0000, r_reg.hybrid};
      default:       rdata = 32'h0000_0000;
    endcase
  end

  // Classification of the offered packet
  always_comb begin
    sp = pkt_port;
    st_src = r_reg.stp[sp];
    pv = r_reg.pvid[sp];
    use_pvid = r_reg.glb[`SVI_G_TAG_DIS] | ~pkt_tagged | (pkt_vid == `SVI_VID_NONE);
    vid = use_pvid ? pv[11:0] : pkt_vid;
    hit = 1'b0;
    mem = 3'h0;
    unt = 3'h0;
    for (int i = 0; i < NUM_VLAN; i++) begin
      if (r_reg.vtab[i][`SVI_E_VALID] && r_reg.vtab[i][11:0] == vid) begin
        hit = 1'b1;
        mem = r_reg.vtab[i][`SVI_E_MEM_LO +: 3];
        unt = r_reg.vtab[i][`SVI_E_UNT_LO +: 3];
      end
    end
    // A miss leaves membership empty, i.e. a foreign VLAN
    dprio = pkt_bcast ? pv[`SVI_P_BPRIO_LO +: 3] : pv[`SVI_P_PRIO_LO +: 3];
    case (r_reg.glb[`SVI_G_PSEL_LO +: 2])
      `SVI_PSEL_IPP:  prio = pkt_is_ipv4 ? pkt_tos[7:5] : dprio;
      `SVI_PSEL_DSCP: prio = (pkt_is_ipv4 | pkt_is_ipv6) ? r_reg.dtab[pkt_tos[7:2]] : dprio;
      `SVI_PSEL_TAG: begin
        if (pkt_tagged & ~r_reg.glb[`SVI_G_TAG_DIS]) begin
          prio = r_reg.remap[sp][5'(pkt_tag_prio) * 5'd3 +: 3];
        end else begin
          prio = dprio;
        end
      end
      default:        prio = dprio;
    endcase
    // Destination candidates, never the source itself
    cand = pkt_da_hit ? pkt_da_ports : 3'h7;
    cand[sp] = 1'b0;
    for (int p = 0; p < NUM_PORT; p++) begin
      if (!(r_reg.stp[p] == `SVI_ST_FWD ||
            (pkt_stp_override && r_reg.stp[p] != `SVI_ST_DIS))) begin
        cand[p] = 1'b0;
      end
    end
    if (r_reg.glb[`SVI_G_VLAN_EN]) begin
      cand = cand & mem;
    end
    drop = 1'b0;
    if (st_src == `SVI_ST_DIS) begin
      drop = 1'b1;
    end
    if ((st_src == `SVI_ST_BLOCK || st_src == `SVI_ST_LEARN) && !pkt_stp_override) begin
      drop = 1'b1;
    end
    if (r_reg.glb[`SVI_G_VLAN_EN] && pkt_tagged && !r_reg.glb[`SVI_G_TAG_DIS] &&
        pkt_vid == `SVI_VID_RSVD) begin
      drop = 1'b1;
    end
    if (r_reg.glb[`SVI_G_VLAN_EN] && r_reg.glb[`SVI_G_MEMCHK] && !mem[sp]) begin
      drop = 1'b1;
    end
    if (cand == 3'h0) begin
      drop = 1'b1;
    end
  end

  assign vidx = r_reg.vcmd[4:0];
  assign pidx = vidx - PV_BASE;
  assign didx = r_reg.dcmd[5:0];

  always_comb begin
    r_next = r_reg;
    r_next.ack = req;
    r_next.dat = req ? rdata : 32'h0000_0000;
    if (wr) begin
      case (wb_adr_i)
        `SVI_A_GLOBAL: r_next.glb = 5'(merge({27'h000_0000, r_reg.glb}, wmask, wb_dat_i));
        `SVI_A_STP:    r_next.stp = 6'(merge({26'h000_0000, r_reg.stp}, wmask, wb_dat_i));
        `SVI_A_REMAP0: r_next.remap[0] = 24'(merge({8'h00, r_reg.remap[0]}, wmask, wb_dat_i));
        `SVI_A_REMAP1: r_next.remap[1] = 24'(merge({8'h00, r_reg.remap[1]}, wmask, wb_dat_i));
        `SVI_A_REMAP2: r_next.remap[2] = 24'(merge({8'h00, r_reg.remap[2]}, wmask, wb_dat_i));
        `SVI_A_TCLASS: r_next.tclass = 16'(merge({16'h0000, r_reg.tclass}, wmask, wb_dat_i));
        `SVI_A_VWR:    r_next.vwr = merge(r_reg.vwr, wmask, wb_dat_i);
        `SVI_A_DWR:    r_next.dwr = merge(r_reg.dwr, wmask, wb_dat_i);
        `SVI_A_HYBRID: r_next.hybrid = 3'(merge({29'h0000_0000, r_reg.hybrid}, wmask, wb_dat_i));
        default: ;
      endcase
    end
    // VLAN and PVID table engine; commands while busy are ignored
    case (r_reg.vst)
      svi_pkg::SVI_IDLE: begin
        if (wr && wb_adr_i == `SVI_A_VCMD) begin
          r_next.vcmd = merge(r_reg.vcmd, wmask, wb_dat_i);
          r_next.vst = svi_pkg::SVI_BUSY;
        end
      end
      svi_pkg::SVI_BUSY: begin
        if (vidx < PV_BASE) begin
          if (r_reg.vcmd[`SVI_C_WRITE]) begin
            r_next.vtab[vidx[VW-1:0]] = r_reg.vwr[18:0];
          end else begin
            r_next.vrd = {13'h0000, r_reg.vtab[vidx[VW-1:0]]};
          end
        end else if (vidx < PV_END) begin
          if (r_reg.vcmd[`SVI_C_WRITE]) begin
            r_next.pvid[pidx[1:0]] = r_reg.vwr[17:0];
          end else begin
            r_next.vrd = {14'h0000, r_reg.pvid[pidx[1:0]]};
          end
        end else begin
          r_next.vrd = 32'h0000_0000;
        end
        r_next.vst = svi_pkg::SVI_IDLE;
      end
      default: r_next.vst = svi_pkg::SVI_IDLE;
    endcase
    // DSCP table engine
    case (r_reg.dst)
      svi_pkg::SVI_IDLE: begin
        if (wr && wb_adr_i == `SVI_A_DCMD) begin
          r_next.dcmd = merge(r_reg.dcmd, wmask, wb_dat_i);
          r_next.dst = svi_pkg::SVI_BUSY;
        end
      end
      svi_pkg::SVI_BUSY: begin
        if (r_reg.dcmd[`SVI_C_WRITE]) begin
          r_next.dtab[didx] = r_reg.dwr[2:0];
        end else begin
          r_next.drd = {29'h0000_0000, r_reg.dtab[didx]};
        end
        r_next.dst = svi_pkg::SVI_IDLE;
      end
      default: r_next.dst = svi_pkg::SVI_IDLE;
    endcase
    // Result stage, one cycle after the packet is offered
    r_next.valid = pkt_valid;
    r_next.drop = pkt_valid & drop;
    r_next.prio = prio;
    r_next.queue = r_reg.tclass[prio];
    r_next.vid = vid;
    r_next.dest = drop ? 3'h0 : cand;
    r_next.untag = drop ? 3'h0 : (cand & unt & r_reg.hybrid);
    r_next.learn = pkt_valid & ~st_src[0];
  end

  // Table contents clear at reset only for determinism; software must still fill them
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '0;
      r_reg.vst <= svi_pkg::SVI_IDLE;
      r_reg.dst <= svi_pkg::SVI_IDLE;
      r_reg.tclass <= `SVI_TCLASS_RST;
      for (int p = 0; p < NUM_PORT; p++) begin
        r_reg.remap[p] <= `SVI_REMAP_RST;
      end
    end else begin
      r_reg <= r_next;
    end
  end

  assign wb_dat_o = r_reg.dat;
  assign wb_ack_o = r_reg.ack;
  assign res_valid = r_reg.valid;
  assign res_drop = r_reg.drop;
  assign res_prio = r_reg.prio;
  assign res_queue = r_reg.queue;
  assign res_vid = r_reg.vid;
  assign res_dest = r_reg.dest;
  assign res_untag = r_reg.untag;
  assign res_learn = r_reg.learn;

endmodule
`default_nettype wire

// ===== sim/svi_ingress_props.sv
// Port-level assertions for the ingress classifier
`timescale 1ns/1ps
`default_nettype none
`include "svi_regs.svh"

module svi_ingress_props (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        pkt_valid,
  input wire logic [1:0]  pkt_port,
  input wire logic        pkt_tagged,
  input wire logic [11:0] pkt_vid,
  input wire logic        pkt_is_ipv4,
  input wire logic [7:0]  pkt_tos,
  input wire logic        res_valid,
  input wire logic        res_drop,
  input wire logic [2:0]  res_prio,
  input wire logic        res_learn
);
  // Shadows assume whole-word writes, as the bench makes
  logic [7:0] glob_reg;
  logic [5:0] stp_reg;
  logic       wr_take;
  logic [1:0] src_st;
  assign wr_take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign src_st  = stp_reg[pkt_port*2 +: 2];
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      glob_reg <= 8'h00;
      stp_reg  <= 6'h00;
    end else begin
      if (wr_take && wb_adr_i == `SVI_A_GLOBAL) glob_reg <= wb_dat_i[7:0];
      if (wr_take && wb_adr_i == `SVI_A_STP) stp_reg <= wb_dat_i[5:0];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request without ack");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  rdata_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  res_delay_a: assert property (pkt_valid |=> res_valid)
    else $error("result strobe missing");
  res_gate_a: assert property (res_drop || res_learn |-> res_valid)
    else $error("drop or learn without result");
  vid_fff_a: assert property (pkt_valid && glob_reg[0] && !glob_reg[1] && pkt_tagged
    && pkt_vid == `SVI_VID_RSVD |=> res_drop)
    else $error("reserved vid passed");
  prec_prio_a: assert property (pkt_valid && glob_reg[3:2] == `SVI_PSEL_IPP && pkt_is_ipv4
    |=> res_prio == ($past(pkt_tos) >> 5))
    else $error("precedence priority wrong");
  src_disabled_a: assert property (pkt_valid && src_st == `SVI_ST_DIS |=> res_drop)
    else $error("disabled port received");
  learn_on_a: assert property (pkt_valid && !src_st[0] |=> res_learn)
    else $error("learning missing");
  learn_off_a: assert property (pkt_valid && src_st[0] |=> !res_learn)
    else $error("learning in blocked state");
  cover property (pkt_valid ##1 res_drop);
  cover property (wr_take && wb_adr_i == `SVI_A_DCMD);
  cover property (pkt_valid && glob_reg[3:2] == `SVI_PSEL_TAG);
endmodule
`default_nettype wire

// ===== sim/svi_ingress_tb.sv
// Self-checking bench for the ingress classifier
`timescale 1ns/1ps
`default_nettype none
`include "svi_regs.svh"

module svi_ingress_tb;
  logic        clk_sys = 1'h0;
  logic        rst_n = 1'h0;
  logic        wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rd;
  logic        wb_ack_o, res_valid, res_drop, res_learn;
  logic        pkt_valid = 1'h0, pkt_tagged = 1'h0, pkt_is_ipv4 = 1'h0, pkt_is_ipv6 = 1'h0;
  logic        pkt_bcast = 1'h0, pkt_da_hit = 1'h0, pkt_stp_override = 1'h0;
  logic [1:0]  pkt_port = 2'h0, res_queue;
  logic [11:0] pkt_vid = 12'h000, res_vid;
  logic [2:0]  pkt_tag_prio = 3'h0, pkt_da_ports = 3'h0, res_prio, res_dest, res_untag;
  logic [7:0]  pkt_tos = 8'h00;
  logic [23:0] remap;
  int          failures = 0;
  int          n_checks = 0;
  int          cycles = 0;

  svi_ingress dut (
    .clk_sys          (clk_sys),
    .rst_n            (rst_n),
    .wb_cyc_i         (wb_cyc_i),
    .wb_stb_i         (wb_stb_i),
    .wb_we_i          (wb_we_i),
    .wb_adr_i         (wb_adr_i),
    .wb_sel_i         (wb_sel_i),
    .wb_dat_i         (wb_dat_i),
    .wb_dat_o         (wb_dat_o),
    .wb_ack_o         (wb_ack_o),
    .pkt_valid        (pkt_valid),
    .pkt_port         (pkt_port),
    .pkt_tagged       (pkt_tagged),
    .pkt_vid          (pkt_vid),
    .pkt_tag_prio     (pkt_tag_prio),
    .pkt_is_ipv4      (pkt_is_ipv4),
    .pkt_is_ipv6      (pkt_is_ipv6),
    .pkt_tos          (pkt_tos),
    .pkt_bcast        (pkt_bcast),
    .pkt_da_hit       (pkt_da_hit),
    .pkt_da_ports     (pkt_da_ports),
    .pkt_stp_override (pkt_stp_override),
    .res_valid        (res_valid),
    .res_drop         (res_drop),
    .res_prio         (res_prio),
    .res_queue        (res_queue),
    .res_vid          (res_vid),
    .res_dest         (res_dest),
    .res_untag        (res_untag),
    .res_learn        (res_learn)
  );

  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      $display("mismatch at %0t: timeout", $time);
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    // Ack is looked at mid-cycle; the next rising clock edge then ends the request
    do @(negedge clk_sys); while (wb_ack_o !== 1'h1);
    rd = wb_dat_o;
    @(posedge clk_sys);
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    wb_we_i  <= 1'h0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'h0, a, 32'h0000_0000);
    chk(rd, exp, "register read");
  endtask

  // Status sits twelve bytes above its command register for both tables
  task automatic tcmd(input logic [7:0] a, input logic [31:0] cmd);
    wb(1'h1, a, cmd);
    repeat (4) begin
      wb(1'h0, a + 8'h0C, 32'h0000_0000);
      if (rd[0] === 1'h0) break;
    end
    chk(rd, 32'h0000_0000, "command pending");
  endtask

  task automatic pk(input logic [1:0] p, input logic tg, input logic [11:0] v,
                    input logic [2:0] tp, input logic [7:0] tos, input logic bc, input logic ov);
    @(posedge clk_sys);
    pkt_valid        <= 1'h1;
    pkt_port         <= p;
    pkt_tagged       <= tg;
    pkt_vid          <= v;
    pkt_tag_prio     <= tp;
    pkt_tos          <= tos;
    pkt_is_ipv4      <= 1'h1;
    pkt_bcast        <= bc;
    pkt_stp_override <= ov;
    @(posedge clk_sys);
    pkt_valid <= 1'h0;
    #1;
  endtask

  task automatic ex(input logic d, input logic [2:0] pr, input logic [2:0] ds);
    chk(res_valid, 1'h1, "result strobe");
    chk(res_drop, d, "drop");
    if (!d) begin
      chk(res_prio, pr, "priority");
      chk(res_queue, 2'(`SVI_TCLASS_RST >> (2 * pr)), "queue");
      chk(res_dest, ds, "destinations");
    end
  endtask

  function automatic logic [2:0] dsv(input int i);
    return 3'(i ^ (i >> 3));
  endfunction

  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'h1;
    rchk(`SVI_A_TCLASS, {16'h0000, `SVI_TCLASS_RST});
    for (int i = 0; i < 3; i++) rchk(`SVI_A_REMAP0 + 8'(4 * i), {8'h00, `SVI_REMAP_RST});
    rchk(`SVI_A_STP, 32'h0000_0000);
    wb(1'h1, 8'hFC, 32'hFFFF_FFFF);
    rchk(8'hFC, 32'h0000_0000);
    wb(1'h1, `SVI_A_VRD, 32'hFFFF_FFFF);
    rchk(`SVI_A_VRD, 32'h0000_0000);
    $display("test reset done");
    wb(1'h1, `SVI_A_VWR, 32'h0004_B005);
    tcmd(`SVI_A_VCMD, 32'h4000_0000);
    wb(1'h1, `SVI_A_VWR, 32'h0004_6123);
    tcmd(`SVI_A_VCMD, 32'h4000_0001);
    wb(1'h1, `SVI_A_VWR, 32'h0001_5005);
    tcmd(`SVI_A_VCMD, 32'h4000_0011);
    tcmd(`SVI_A_VCMD, 32'h0000_0000);
    rchk(`SVI_A_VRD, 32'h0004_B005);
    tcmd(`SVI_A_VCMD, 32'h0000_0011);
    rchk(`SVI_A_VRD, 32'h0001_5005);
    for (int i = 0; i < 64; i++) begin
      wb(1'h1, `SVI_A_DWR, 32'(dsv(i)));
      tcmd(`SVI_A_DCMD, 32'h4000_0000 | 32'(i));
    end
    tcmd(`SVI_A_DCMD, 32'h0000_002E);
    rchk(`SVI_A_DRD, 32'(dsv(46)));
    $display("test tables done");
    wb(1'h1, `SVI_A_GLOBAL, 32'h0000_0008);
    for (int i = 0; i < 64; i += 7) begin
      pk(2'h0, 1'h0, 12'h000, 3'h0, 8'(i << 2) | 8'h01, 1'h0, 1'h0);
      ex(1'h0, dsv(i), 3'h6);
    end
    wb(1'h1, `SVI_A_GLOBAL, 32'h0000_0004);
    for (int t = 0; t < 8; t++) begin
      pk(2'h0, 1'h1, 12'h123, 3'h7, 8'(t << 5) | 8'h1C, 1'h0, 1'h0);
      ex(1'h0, 3'(t), 3'h6);
    end
    for (int n = 0; n < 8; n++) remap[3 * n +: 3] = 3'(7 - n);
    wb(1'h1, `SVI_A_REMAP1, {8'h00, remap});
    wb(1'h1, `SVI_A_GLOBAL, 32'h0000_000C);
    for (int n = 0; n < 8; n++) begin
      pk(2'h1, 1'h1, 12'h123, 3'(n), 8'h00, 1'h0, 1'h0);
      ex(1'h0, 3'(7 - n), 3'h5);
    end
    $display("test priority sources done");
    wb(1'h1, `SVI_A_GLOBAL, 32'h0000_0001);
    pk(2'h1, 1'h0, 12'h000, 3'h0, 8'h00, 1'h0, 1'h0);
    ex(1'h0, 3'h5, 3'h1);
    chk(res_untag, 3'h0, "untag off");
    wb(1'h1, `SVI_A_HYBRID, 32'h0000_0007);
    pk(2'h1, 1'h0, 12'h000, 3'h0, 8'h00, 1'h1, 1'h0);
    ex(1'h0, 3'h2, 3'h1);
    chk(res_untag, 3'h1, "untag hybrid");
    pk(2'h1, 1'h1, 12'h000, 3'h3, 8'h00, 1'h0, 1'h0);
    ex(1'h0, 3'h5, 3'h1);
    chk(res_vid, 12'h005, "priority tag vid");
    pk(2'h1, 1'h1, 12'h123, 3'h3, 8'h00, 1'h0, 1'h0);
    ex(1'h0, 3'h5, 3'h4);
    chk(res_vid, 12'h123, "tag vid");
    pk(2'h1, 1'h1, `SVI_VID_RSVD, 3'h0, 8'h00, 1'h0, 1'h0);
    ex(1'h1, 3'h0, 3'h0);
    pk(2'h1, 1'h1, 12'h777, 3'h0, 8'h00, 1'h0, 1'h0);
    ex(1'h1, 3'h0, 3'h0);
    pk(2'h0, 1'h1, 12'h123, 3'h0, 8'h00, 1'h0, 1'h0);
    ex(1'h0, 3'h0, 3'h6);
    wb(1'h1, `SVI_A_GLOBAL, 32'h0000_0011);
    pk(2'h0, 1'h1, 12'h123, 3'h0, 8'h00, 1'h0, 1'h0);
    ex(1'h1, 3'h0, 3'h0);
    wb(1'h1, `SVI_A_GLOBAL, 32'h0000_0003);
    pk(2'h1, 1'h1, 12'h123, 3'h0, 8'h00, 1'h0, 1'h0);
    ex(1'h0, 3'h5, 3'h1);
    chk(res_vid, 12'h005, "port vlan vid");
    $display("test vlan done");
    wb(1'h1, `SVI_A_GLOBAL, 32'h0000_0000);
    pkt_da_hit   <= 1'h1;
    pkt_da_ports <= 3'h4;
    pk(2'h0, 1'h0, 12'h000, 3'h0, 8'h00, 1'h0, 1'h0);
    ex(1'h0, 3'h0, 3'h4);
    pkt_da_ports <= 3'h3;
    pk(2'h0, 1'h0, 12'h000, 3'h0, 8'h00, 1'h0, 1'h0);
    ex(1'h0, 3'h0, 3'h2);
    pkt_da_hit   <= 1'h0;
    pkt_da_ports <= 3'h0;
    for (int s = 0; s < 4; s++) begin
      wb(1'h1, `SVI_A_STP, 32'(s * 20));
      for (int k = 0; k < 4; k++) begin
        pk(2'(k >> 1), 1'h0, 12'h000, 3'h0, 8'h00, 1'h0, 1'(k));
        ex(s != 0 && (!k[0] || s == 3), (k > 1) ? 3'h5 : 3'h0, (k > 1) ? 3'h5 : 3'h6);
        chk(res_learn, k < 2 || !s[0], "learn");
      end
    end
    $display("test spanning states done");
    summarize();
  end
endmodule

bind svi_ingress svi_ingress_props u_props (
  .clk_sys     (clk_sys),
  .rst_n       (rst_n),
  .wb_cyc_i    (wb_cyc_i),
  .wb_stb_i    (wb_stb_i),
  .wb_we_i     (wb_we_i),
  .wb_adr_i    (wb_adr_i),
  .wb_dat_i    (wb_dat_i),
  .wb_dat_o    (wb_dat_o),
  .wb_ack_o    (wb_ack_o),
  .pkt_valid   (pkt_valid),
  .pkt_port    (pkt_port),
  .pkt_tagged  (pkt_tagged),
  .pkt_vid     (pkt_vid),
  .pkt_is_ipv4 (pkt_is_ipv4),
  .pkt_tos     (pkt_tos),
  .res_valid   (res_valid),
  .res_drop    (res_drop),
  .res_prio    (res_prio),
  .res_learn   (res_learn)
);
`default_nettype wire
